// ==== rtl/mtu_trigger_unit.v ====
// top of the measurement trigger unit with its register slave
`include "mtu_defs.vh"
`default_nettype none

module mtu_trigger_unit #(
  parameter [31:0] P_MIN_PERIOD_CYCLES = `MTU_MIN_PERIOD_MS * `MTU_CLK_KHZ,
  parameter [31:0] P_MAX_SWEEP_CYCLES = `MTU_MAX_SWEEP_CYCLES
) (
  input wire i_sys_clk,
  input wire i_reset_n,
  input wire i_s_axi_awvalid,
  output reg o_s_axi_awready,
  input wire [7:0] i_s_axi_awaddr,
  input wire i_s_axi_wvalid,
  output reg o_s_axi_wready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  output reg [1:0] o_s_axi_bresp,
  input wire i_s_axi_arvalid,
  output reg o_s_axi_arready,
  input wire [7:0] i_s_axi_araddr,
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready,
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  input wire [15:0] i_ext1_sample,
  input wire [15:0] i_second_external_input_source_sample,
  input wire [15:0] i_envelope_sample,
  input wire [15:0] i_ifp_start_sample,
  input wire [15:0] i_ifp_center_sample,
  input wire i_sensor_pulse,
  output reg o_trigger,
  output reg o_sweep_start,
  output reg [31:0] o_pretrig_cycles,
  output reg o_acquire,
  output reg o_gate_open,
  output reg o_trigger_indicator
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [31:0] mtu_merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer k;
    begin
      mtu_merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          mtu_merge[k*8 +: 8] = data[k*8 +: 8];
    end
  endfunction

  function mtu_mapped;
    input [7:0] addr;
    begin
      mtu_mapped = (addr[1:0] == 2'b00) && (addr <= `MTU_OFS_STATUS);
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [`MTU_CTRL_WIDTH-1:0] ctrl;
  reg [15:0] level;
  reg [5:0] ifp_hyst;
  reg [31:0] dropout_time;
  reg [31:0] holdoff_time;
  reg [31:0] offset_time;
  reg [31:0] repeat_period;
  reg [31:0] gate_length;
  reg refused;
  reg [15:0] trig_count;

  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  reg [31:0] holdoff_cnt;
  reg [31:0] delay_cnt;
  reg delay_busy;
  reg [31:0] timer_cnt;
  reg [31:0] gate_cnt;

  wire [2:0] src = ctrl[`MTU_CTRL_SRC_MSB:`MTU_CTRL_SRC_LSB];
  wire falling = ctrl[`MTU_CTRL_FALLING];
  wire gate_en = ctrl[`MTU_CTRL_GATE_EN];
  wire gate_lvl = ctrl[`MTU_CTRL_GATE_LEVEL];

  // ----------------------------------------------------------------
  // write validation
  // ----------------------------------------------------------------
  wire [31:0] wr_old = (aw_addr == `MTU_OFS_CTRL) ? {20'h0, ctrl} :
                       (aw_addr == `MTU_OFS_LEVEL) ? {16'h0, level} :
                       (aw_addr == `MTU_OFS_IFP_HYST) ? {26'h0, ifp_hyst} :
                       (aw_addr == `MTU_OFS_DROPOUT) ? dropout_time :
                       (aw_addr == `MTU_OFS_HOLDOFF) ? holdoff_time :
                       (aw_addr == `MTU_OFS_OFFSET) ? offset_time :
                       (aw_addr == `MTU_OFS_REPEAT) ? repeat_period :
                       gate_length;
  wire [31:0] wr_val = mtu_merge(wr_old, w_data, w_strb);
  wire [2:0] new_src = wr_val[`MTU_CTRL_SRC_MSB:`MTU_CTRL_SRC_LSB];
  wire [31:0] off_mag = offset_time[31] ? (32'h0 - offset_time) : 32'h0;
  wire [31:0] new_mag = wr_val[31] ? (32'h0 - wr_val) : 32'h0;
  // a control word is refused as a whole if it names an illegal setup
  wire ctrl_bad =
    (new_src > `MTU_SRC_TIMER) ||
    // envelope source not offered on I/Q data
    (new_src == `MTU_SRC_ENVELOPE && wr_val[`MTU_CTRL_IQ_DATA]) ||
    // intermediate power needs the RF input
    (new_src == `MTU_SRC_IFP && !wr_val[`MTU_CTRL_RF_INPUT]) ||
    // second connector only when set to input
    (new_src == `MTU_SRC_SECOND_EXTERNAL_INPUT_SOURCE && !wr_val[`MTU_CTRL_SECOND_EXTERNAL_INPUT_SOURCE_IN]) ||
    // no level gating from the sensor pulse
    (new_src == `MTU_SRC_SENSOR && wr_val[`MTU_CTRL_GATE_EN] &&
     wr_val[`MTU_CTRL_GATE_LEVEL]) ||
    // a stored pretrigger must stay legal
    (offset_time[31] && (!wr_val[`MTU_CTRL_ZERO_SPAN] ||
     wr_val[`MTU_CTRL_GATE_EN]));
  wire wr_bad =
    (aw_addr == `MTU_OFS_CTRL) ? ctrl_bad :
    // band of 3 to 50 dB
    (aw_addr == `MTU_OFS_IFP_HYST) ?
      (wr_val[5:0] < `MTU_IFP_HYST_MIN || wr_val[5:0] > `MTU_IFP_HYST_MAX ||
       wr_val[31:6] != 26'h0) :
    // repeat period under the minimum refused
    (aw_addr == `MTU_OFS_REPEAT) ? (wr_val < P_MIN_PERIOD_CYCLES) :
    // pretrigger only zero span, gate off, within max sweep time
    (aw_addr == `MTU_OFS_OFFSET) ?
      (wr_val[31] && (!ctrl[`MTU_CTRL_ZERO_SPAN] || gate_en ||
       new_mag > P_MAX_SWEEP_CYCLES)) :
    1'b0;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel: address and data taken in either order
  // ----------------------------------------------------------------
  wire wr_go = aw_held && w_held && !o_s_axi_bvalid;
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready <= 1'b0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= 2'b00;
      // free run selected, IFP band at its minimum of 3, repeat period at the minimum, everything else cleared
      ctrl <= `MTU_RST_CTRL;
      level <= `MTU_RST_LEVEL;
      ifp_hyst <= `MTU_RST_IFP_HYST;
      dropout_time <= 32'h0;
      holdoff_time <= 32'h0;
      offset_time <= 32'h0;
      repeat_period <= P_MIN_PERIOD_CYCLES;
      gate_length <= 32'h0;
      refused <= 1'b0;
    end else begin
      // ready is offered one cycle ahead, dropped while holding
      o_s_axi_awready <= !aw_held && !(o_s_axi_awready && i_s_axi_awvalid);
      o_s_axi_wready <= !w_held && !(o_s_axi_wready && i_s_axi_wvalid);
      if (o_s_axi_awready && i_s_axi_awvalid) begin
        aw_held <= 1'b1;
        aw_addr <= i_s_axi_awaddr;
      end
      if (o_s_axi_wready && i_s_axi_wvalid) begin
        w_held <= 1'b1;
        w_data <= i_s_axi_wdata;
        w_strb <= i_s_axi_wstrb;
      end
      if (o_s_axi_bvalid && i_s_axi_bready)
        o_s_axi_bvalid <= 1'b0;
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= mtu_mapped(aw_addr) ? 2'b00 : 2'b10;
        // refused values leave the register unchanged, flag is readable
        if (mtu_mapped(aw_addr) && aw_addr != `MTU_OFS_STATUS)
          refused <= wr_bad;
        if (mtu_mapped(aw_addr) && !wr_bad) begin
          case (aw_addr)
            `MTU_OFS_CTRL: ctrl <= wr_val[`MTU_CTRL_WIDTH-1:0];
            `MTU_OFS_LEVEL: level <= wr_val[15:0];
            `MTU_OFS_IFP_HYST: ifp_hyst <= wr_val[5:0];
            `MTU_OFS_DROPOUT: dropout_time <= wr_val;
            `MTU_OFS_HOLDOFF: holdoff_time <= wr_val;
            `MTU_OFS_OFFSET: offset_time <= wr_val;
            `MTU_OFS_REPEAT: repeat_period <= wr_val;
            `MTU_OFS_GATE_LEN: gate_length <= wr_val;
            default: refused <= refused;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0;
      o_s_axi_rresp <= 2'b00;
    end else begin
      o_s_axi_arready <= !o_s_axi_rvalid &&
                         !(o_s_axi_arready && i_s_axi_arvalid);
      if (o_s_axi_rvalid && i_s_axi_rready)
        o_s_axi_rvalid <= 1'b0;
      if (o_s_axi_arready && i_s_axi_arvalid) begin
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rresp <= mtu_mapped(i_s_axi_araddr) ? 2'b00 : 2'b10;
        case (i_s_axi_araddr)
          `MTU_OFS_CTRL: o_s_axi_rdata <= {20'h0, ctrl};
          `MTU_OFS_LEVEL: o_s_axi_rdata <= {16'h0, level};
          `MTU_OFS_IFP_HYST: o_s_axi_rdata <= {26'h0, ifp_hyst};
          `MTU_OFS_DROPOUT: o_s_axi_rdata <= dropout_time;
          `MTU_OFS_HOLDOFF: o_s_axi_rdata <= holdoff_time;
          `MTU_OFS_OFFSET: o_s_axi_rdata <= offset_time;
          `MTU_OFS_REPEAT: o_s_axi_rdata <= repeat_period;
          `MTU_OFS_GATE_LEN: o_s_axi_rdata <= gate_length;
          `MTU_OFS_STATUS: o_s_axi_rdata <= {trig_count, 10'h0,
            o_trigger_indicator, delay_busy, o_gate_open,
            holdoff_cnt != 32'h0, o_acquire, refused};
          default: o_s_axi_rdata <= 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // source selection and comparator setup
  // ----------------------------------------------------------------
  reg [15:0] sel_sample;
  reg [15:0] sel_level;
  reg [15:0] sel_hyst;
  always @* begin
    sel_sample = 16'h0000;
    sel_level = level;
    sel_hyst = 16'h0000;
    case (src)
      // external input compared against the threshold on the selected slope
      `MTU_SRC_EXT1: sel_sample = i_ext1_sample;
      `MTU_SRC_SECOND_EXTERNAL_INPUT_SOURCE: sel_sample = i_second_external_input_source_sample;
      `MTU_SRC_ENVELOPE: begin
        sel_sample = i_envelope_sample;
        // threshold in 0.1 % steps, saturates at full height
        if (level > `MTU_ENV_FULL_SCALE)
          sel_level = `MTU_ENV_FULL_SCALE;
        // fixed hysteresis of one tenth of the threshold
        sel_hyst = sel_level / `MTU_ENV_HYST_DIV;
      end
      `MTU_SRC_IFP: begin
        // start frequency for sweeps, centre otherwise
        sel_sample = ctrl[`MTU_CTRL_FREQ_SWEEP] ? i_ifp_start_sample :
                     i_ifp_center_sample;
        // programmable band in 1 dB steps
        sel_hyst = {10'h000, ifp_hyst};
      end
      default: sel_sample = 16'h0000;
    endcase
  end

  wire cmp_en = (src == `MTU_SRC_EXT1) || (src == `MTU_SRC_SECOND_EXTERNAL_INPUT_SOURCE) ||
                (src == `MTU_SRC_ENVELOPE) || (src == `MTU_SRC_IFP);
  wire cmp_event;
  wire cmp_active;

  // one comparator serves both trigger and gate threshold
  mtu_level_detect u_detect (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_enable(cmp_en),
    .i_sample(sel_sample),
    .i_level(sel_level),
    .i_hyst(sel_hyst),
    .i_falling(falling),
    .i_dropout(dropout_time),
    .o_event(cmp_event),
    .o_active(cmp_active)
  );

  // ----------------------------------------------------------------
  // event qualification, holdoff, offset and timer
  // ----------------------------------------------------------------
  // comparator events inside the holdoff are discarded
  wire cmp_accept = cmp_event && (holdoff_cnt == 32'h0);
  // the sensor pulse is already qualified by the sensor itself
  wire sensor_accept = (src == `MTU_SRC_SENSOR) && i_sensor_pulse;
  wire timer_tick = (src == `MTU_SRC_TIMER) &&
                    (timer_cnt + 32'h1 >= repeat_period);
  wire accept = cmp_accept || sensor_accept || timer_tick;
  wire use_offset = (src != `MTU_SRC_TIMER);
  wire positive_delay = use_offset && !offset_time[31] &&
                        (offset_time != 32'h0);

  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      holdoff_cnt <= 32'h0;
      delay_cnt <= 32'h0;
      delay_busy <= 1'b0;
      timer_cnt <= 32'h0;
      gate_cnt <= 32'h0;
      trig_count <= 16'h0000;
      o_trigger <= 1'b0;
      o_sweep_start <= 1'b0;
      o_pretrig_cycles <= 32'h0;
      o_acquire <= 1'b0;
      o_gate_open <= 1'b0;
      o_trigger_indicator <= 1'b0;
    end else begin
      o_trigger_indicator <= (src != `MTU_SRC_FREE_RUN);
      o_trigger <= accept;
      o_sweep_start <= 1'b0;
      if (accept)
        trig_count <= trig_count + 16'h0001;
      // holdoff restarts at each accepted comparator event
      if (cmp_accept)
        holdoff_cnt <= holdoff_time;
      else if (holdoff_cnt != 32'h0)
        holdoff_cnt <= holdoff_cnt - 32'h1;
      // free-running period counter while the timer is selected
      if (src != `MTU_SRC_TIMER || timer_tick)
        timer_cnt <= 32'h0;
      else
        timer_cnt <= timer_cnt + 32'h1;
      // positive offset counts down before the sweep starts
      if (accept && positive_delay) begin
        delay_busy <= 1'b1;
        delay_cnt <= offset_time - 32'h1;
      end else if (accept) begin
        // pretrigger depth handed out with the start pulse
        o_sweep_start <= 1'b1;
        o_pretrig_cycles <= use_offset ? off_mag : 32'h0;
      end else if (delay_busy) begin
        if (delay_cnt == 32'h0) begin
          delay_busy <= 1'b0;
          o_sweep_start <= 1'b1;
          o_pretrig_cycles <= 32'h0;
        end else begin
          delay_cnt <= delay_cnt - 32'h1;
        end
      end
      // free run acquires on command until stopped
      if (src == `MTU_SRC_FREE_RUN) begin
        o_acquire <= ctrl[`MTU_CTRL_RUN];
        delay_busy <= 1'b0;
      end else if (o_sweep_start) begin
        o_acquire <= 1'b1;
      end else if (!ctrl[`MTU_CTRL_RUN]) begin
        o_acquire <= 1'b0;
      end
      // gate: level mode follows the comparator, edge mode runs a length
      if (!gate_en || src == `MTU_SRC_FREE_RUN) begin
        o_gate_open <= 1'b0;
        gate_cnt <= 32'h0;
      end else if (gate_lvl) begin
        // gate level is the trigger threshold
        o_gate_open <= cmp_active;
      end else if (accept && gate_length != 32'h0) begin
        // edge mode opens on each accepted trigger while gate_length is nonzero, whatever the source
        o_gate_open <= 1'b1;
        gate_cnt <= gate_length - 32'h1;
      end else if (gate_cnt != 32'h0) begin
        gate_cnt <= gate_cnt - 32'h1;
      end else begin
        o_gate_open <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ==== rtl/mtu_defs.vh ====
// constants for the measurement trigger unit: offsets, fields, resets, timing
`ifndef MTU_DEFS_VH
`define MTU_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define MTU_OFS_CTRL 8'h00
`define MTU_OFS_LEVEL 8'h04
`define MTU_OFS_IFP_HYST 8'h08
`define MTU_OFS_DROPOUT 8'h0c
`define MTU_OFS_HOLDOFF 8'h10
`define MTU_OFS_OFFSET 8'h14
`define MTU_OFS_REPEAT 8'h18
`define MTU_OFS_GATE_LEN 8'h1c
`define MTU_OFS_STATUS 8'h20

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define MTU_CTRL_SRC_LSB 0
`define MTU_CTRL_SRC_MSB 2
`define MTU_CTRL_FALLING 3
`define MTU_CTRL_GATE_EN 4
`define MTU_CTRL_GATE_LEVEL 5
`define MTU_CTRL_IQ_DATA 6
`define MTU_CTRL_RF_INPUT 7
`define MTU_CTRL_ZERO_SPAN 8
`define MTU_CTRL_FREQ_SWEEP 9
`define MTU_CTRL_RUN 10
`define MTU_CTRL_SECOND_EXTERNAL_INPUT_SOURCE_IN 11
`define MTU_CTRL_WIDTH 12

// ----------------------------------------------------------------
// source encodings
// ----------------------------------------------------------------
`define MTU_SRC_FREE_RUN 3'h0
`define MTU_SRC_EXT1 3'h1
`define MTU_SRC_SECOND_EXTERNAL_INPUT_SOURCE 3'h2
`define MTU_SRC_ENVELOPE 3'h3
`define MTU_SRC_IFP 3'h4
`define MTU_SRC_SENSOR 3'h5
`define MTU_SRC_TIMER 3'h6

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define MTU_RST_CTRL 12'h000
`define MTU_RST_LEVEL 16'h0000
`define MTU_RST_IFP_HYST 6'h03
`define MTU_IFP_HYST_MIN 6'h03
`define MTU_IFP_HYST_MAX 6'h32
`define MTU_ENV_FULL_SCALE 16'h03e8
`define MTU_ENV_HYST_DIV 16'h000a

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MTU_CLK_KHZ 20000
`define MTU_MIN_PERIOD_MS 2
`define MTU_MAX_SWEEP_CYCLES 32'h01312d00

`endif

// ==== rtl/mtu_level_detect.v ====
// threshold crossing detector with hysteresis, slope and drop-out qualification
`include "mtu_defs.vh"
`default_nettype none

module mtu_level_detect (
  input wire i_sys_clk,
  input wire i_reset_n,
  input wire i_enable,
  input wire [15:0] i_sample,
  input wire [15:0] i_level,
  input wire [15:0] i_hyst,
  input wire i_falling,
  input wire [31:0] i_dropout,
  output reg o_event,
  output reg o_active
);

  // ----------------------------------------------------------------
  // saturating helpers
  // ----------------------------------------------------------------
  function [15:0] mtu_sat_sub;
    input [15:0] a;
    input [15:0] b;
    begin
      mtu_sat_sub = (a > b) ? (a - b) : 16'h0000;
    end
  endfunction

  function [15:0] mtu_sat_add;
    input [15:0] a;
    input [15:0] b;
    reg [16:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      mtu_sat_add = s[16] ? 16'hffff : s[15:0];
    end
  endfunction

  reg armed;
  reg [31:0] quiet_cnt;
  wire [15:0] low_mark = mtu_sat_sub(i_level, i_hyst);
  wire [15:0] high_mark = mtu_sat_add(i_level, i_hyst);
  // quiet means the source sits below the relevant mark this cycle
  wire quiet = i_falling ? (i_sample < i_level) : (i_sample < low_mark);
  // zero drop-out still needs one quiet sample to re-arm
  wire [31:0] need_m1 = (i_dropout == 32'h0) ? 32'h0 : i_dropout - 32'h1;
  wire quiet_done = quiet && (quiet_cnt >= need_m1);

  // ----------------------------------------------------------------
  // arm / fire sequence
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      armed <= 1'b0;
      quiet_cnt <= 32'h0;
      o_event <= 1'b0;
      o_active <= 1'b0;
    end else if (!i_enable) begin
      armed <= 1'b0;
      quiet_cnt <= 32'h0;
      o_event <= 1'b0;
      o_active <= 1'b0;
    end else begin
      if (!quiet)
        quiet_cnt <= 32'h0;
      else if (quiet_cnt != 32'hffffffff)
        quiet_cnt <= quiet_cnt + 32'h1;
      o_active <= i_falling ? (i_sample < i_level) : (i_sample >= i_level);
      o_event <= 1'b0;
      if (!i_falling) begin
        if (armed && i_sample >= i_level) begin
          o_event <= 1'b1;
          armed <= 1'b0;
        end else if (quiet_done) begin
          // re-arm only below hysteresis band for drop-out time
          armed <= 1'b1;
        end
      end else begin
        // falling crossing, qualified by the drop-out time
        if (armed && quiet_done) begin
          o_event <= 1'b1;
          armed <= 1'b0;
        end else if (i_sample > high_mark) begin
          armed <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== bench/mtu_trigger_unit_props.sv ====
// assertions on the trigger unit's bus handshakes and trigger outputs
`default_nettype none
// ----------------------------------------------------------------
// checker
// ----------------------------------------------------------------
module mtu_trigger_unit_props (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic o_trigger,
  input wire logic o_trigger_indicator
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);
  // a write takes both items at one edge; a read takes its address
  sequence s_wtake;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  endsequence
  sequence s_rtake; i_s_axi_arvalid && o_s_axi_arready; endsequence
  // one edge commits the held pair, the next shows the answer
  property p_wresp; s_wtake |-> ##2 o_s_axi_bvalid; endproperty
  a_wresp: assert property (p_wresp) else $error("write answer late");
  property p_rresp;
    s_rtake |=> o_s_axi_rvalid && !o_s_axi_arready;
  endproperty
  a_rresp: assert property (p_rresp) else $error("read answer late");
  property p_bhold;
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_bdone;
    o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid;
  endproperty
  a_bdone: assert property (p_bdone) else $error("write answer repeated");
  property p_rhold;
    o_s_axi_rvalid && !i_s_axi_rready |=>
      o_s_axi_rvalid && $stable(o_s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer changed");
  property p_rdone;
    o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid;
  endproperty
  a_rdone: assert property (p_rdone) else $error("read answer repeated");
  property p_rst;
    $rose(i_reset_n) |-> !o_trigger && !o_trigger_indicator;
  endproperty
  a_rst: assert property (p_rst) else $error("active after reset");
  property p_free; !o_trigger_indicator [*2] |-> !o_trigger; endproperty
  a_free: assert property (p_free) else $error("trigger in free run");
endmodule
bind mtu_trigger_unit mtu_trigger_unit_props u_props (.*);
`default_nettype wire

// ==== bench/mtu_sweep_model.sv ====
// sweep control model: counts triggers and trigger-to-start distance
`default_nettype none
module mtu_sweep_model (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_trigger,
  input wire logic i_sweep_start,
  output logic [7:0] o_trig_cnt,
  output logic [7:0] o_gap
);
  logic [7:0] since;
  // gap is latched at sweep start so a later trigger cannot blur it
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_trig_cnt <= 8'h00;
      o_gap <= 8'h00;
      since <= 8'h00;
    end else begin
      since <= i_trigger ? 8'h01 : since + 8'h01;
      if (i_trigger) o_trig_cnt <= o_trig_cnt + 8'h01;
      if (i_sweep_start) o_gap <= i_trigger ? 8'h00 : since;
    end
  end
endmodule
`default_nettype wire

// ==== bench/mtu_trigger_unit_test.sv ====
// self-checking bench for the measurement trigger unit
`default_nettype none
module mtu_trigger_unit_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, awv, wv, bre, arv, rre, done, awr, wrd, bv, arr, rv;
  logic trigger_indicator, sst, ind, acq, gto;
  logic [1:0] brs, rrs, resp;
  logic [7:0] awa, ara, tcnt, gap, b;
  logic [15:0] smp;
  logic [31:0] wd, rdat, rdd, pre;
  integer err_total, n_compared, i;
  logic [7:0] ta [0:7] = '{8'h18, 8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h14,
    8'h00};
  logic [31:0] td [0:7] = '{32'h27, 32'h43, 32'h04, 32'h33, 32'h02, 32'h35,
    32'hffffffff, 32'h07};
  mtu_trigger_unit #(.P_MIN_PERIOD_CYCLES(32'h28),
    .P_MAX_SWEEP_CYCLES(32'h64)) DUT (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_s_axi_awvalid(awv),
    .o_s_axi_awready(awr), .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wrd), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf),
    .o_s_axi_bvalid(bv), .i_s_axi_bready(bre), .o_s_axi_bresp(brs),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rre), .o_s_axi_rdata(rdat),
    .o_s_axi_rresp(rrs), .i_ext1_sample(smp), .i_second_external_input_source_sample(smp),
    .i_envelope_sample(smp), .i_ifp_start_sample(smp),
    .i_ifp_center_sample(smp), .i_sensor_pulse(1'b0), .o_trigger(trigger_indicator),
    .o_sweep_start(sst), .o_pretrig_cycles(pre), .o_acquire(acq),
    .o_gate_open(gto), .o_trigger_indicator(ind));
  mtu_sweep_model u_far (.i_sys_clk(clk), .i_reset_n(rst_n), .i_trigger(trigger_indicator),
    .i_sweep_start(sst), .o_trig_cnt(tcnt), .o_gap(gap));
  // 20 MHz clock
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task tmo;
    err_total = err_total + 1;
    $display("Error handshake expected answer seen none");
    conclude;
  endtask
  task chkr(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared = n_compared + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chkc(input string nm, input logic [7:0] e, input logic [7:0] g);
    chkr(nm, {24'h0, e}, {24'h0, g});
  endtask
  // bus cycles: answer ready is held up from the request on
  task wr(input logic [7:0] a, input logic [31:0] d);
    integer n;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bre <= 1;
    n = 0;
    done = 0;
    while (!done) begin
      @(posedge clk);
      n = n + 1;
      if (awv && awr) awv <= 0;
      if (wv && wrd) wv <= 0;
      done = bv;
      resp = brs;
      if (n > 99) tmo;
    end
    bre <= 0;
  endtask
  task rd(input logic [7:0] a);
    integer n;
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rre <= 1;
    n = 0;
    done = 0;
    while (!done) begin
      @(posedge clk);
      n = n + 1;
      if (arv && arr) arv <= 0;
      done = rv;
      rdd = rdat;
      resp = rrs;
      if (n > 99) tmo;
    end
    rre <= 0;
  endtask
  task put(input logic [15:0] v, input integer n);
    @(posedge clk);
    smp <= v;
    repeat (n - 1) @(posedge clk);
  endtask
  task t_reset;
    chkc("indicator", 8'h00, {7'h0, ind});
    rd(8'h00);
    chkr("control", 32'h0, rdd);
    rd(8'h18);
    chkr("repeat", 32'h28, rdd);
    rd(8'h24);
    chkr("unmapped", 32'h2, {30'h0, resp});
  endtask
  // each entry is an illegal value; the register must keep its old one
  task t_refuse;
    for (i = 0; i < 8; i = i + 1) begin
      wr(ta[i], td[i]);
      rd(8'h20);
      chkr("refused", 32'h1, rdd & 32'h1);
      rd(ta[i]);
      chkr("kept", (ta[i] == 8'h18) ? 32'h28 :
        (ta[i] == 8'h08) ? 32'h3 : 32'h0, rdd);
    end
    wr(8'h08, 32'h32);
    rd(8'h08);
    chkr("band", 32'h32, rdd);
  endtask
  task t_ext;
    wr(8'h04, 32'h64);
    wr(8'h14, 32'h5);
    // level gate on, so the gate shows the comparator state
    wr(8'h00, 32'h431);
    b = tcnt;
    put(16'h0, 4);
    put(16'h64, 12);
    chkc("rise", b + 8'h01, tcnt);
    chkc("offset", 8'h05, gap);
    chkc("gate", 8'h01, {7'h0, gto});
    wr(8'h00, 32'h409);
    put(16'hc8, 4);
    put(16'h0, 12);
    chkc("fall", b + 8'h02, tcnt);
    wr(8'h14, 32'h0);
    wr(8'h10, 32'h28);
    wr(8'h00, 32'h401);
    put(16'h64, 3);
    put(16'h0, 3);
    put(16'h64, 3);
    put(16'h0, 40);
    put(16'h64, 6);
    chkc("holdoff", b + 8'h04, tcnt);
    wr(8'h10, 32'h0);
    wr(8'h0c, 32'ha);
    // let the holdoff of the last event run out, else it hides the check
    put(16'h64, 40);
    put(16'h0, 5);
    put(16'h64, 4);
    put(16'h0, 12);
    put(16'h64, 6);
    chkc("dropout", b + 8'h05, tcnt);
    wr(8'h00, 32'hd02);
    wr(8'h14, 32'hfffffffd);
    put(16'h0, 12);
    put(16'h64, 6);
    chkr("pretrigger", 32'h3, pre);
  endtask
  task t_timer;
    wr(8'h0c, 32'h0);
    wr(8'h14, 32'h5);
    wr(8'h18, 32'h28);
    wr(8'h00, 32'h406);
    b = tcnt;
    repeat (100) @(posedge clk);
    chkc("period", b + 8'h02, tcnt);
    chkc("no offset", 8'h00, gap);
    chkc("indicator", 8'h01, {7'h0, ind});
    wr(8'h00, 32'h400);
    b = tcnt;
    repeat (60) @(posedge clk);
    chkc("free run", b, tcnt);
    chkc("acquire", 8'h01, {7'h0, acq});
  endtask
  initial begin
    err_total = 0;
    n_compared = 0;
    {rst_n, awv, wv, bre, arv, rre, awa, ara, wd, smp} = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1;
    t_reset;
    t_refuse;
    t_ext;
    t_timer;
    conclude;
  end
endmodule
`default_nettype wire
